// file: sls_pkg.sv
// Shared constants, enumerations and timing counts of the snooze logging sequencer
package sls_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned MINUTE_S = 60;
  localparam logic [33:0] MINUTE_CYCLES = 34'(MINUTE_S * CLK_HZ);
  localparam logic [4:0] INTERVAL_COUNT = 5'h1e;
  localparam int unsigned ALARM_HOURS = 24;
  localparam logic [10:0] ALARM_MINUTES = 11'(ALARM_HOURS * 60);

  // ----------------------------------------------------------------
  // Data widths and buffer
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned IDX_W = 4;
  localparam logic [IDX_W-1:0] BUF_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Power modes and wake causes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_SNOOZE = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_ALARM = 2'h1;
  localparam logic [1:0] CAUSE_BUTTON = 2'h2;
  localparam logic [1:0] CAUSE_CMP = 2'h3;

  // ----------------------------------------------------------------
  // State enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_CONV,
    ST_XFER,
    ST_NORMAL,
    ST_REARM
  } sls_state_t;

  typedef enum logic [2:0] {
    XS_IDLE,
    XS_CH0,
    XS_CH1,
    XS_REF,
    XS_INP,
    XS_CMP
  } sls_xstep_t;

endpackage

// file: sls_xfer_if.sv
// Link between sequencer control and the chained transfer unit
`timescale 1ns/100ps
interface sls_xfer_if;
  logic conv_end;
  logic [11:0] ch0;
  logic [11:0] ch1;
  logic [11:0] threshold;
  logic [3:0] rd_idx;
  logic done;
  logic hit;
  logic [3:0] wr_idx;
  logic [11:0] rd_ch0;
  logic [11:0] rd_ch1;

  // Sequencer side
  modport ctrl (
    output conv_end, ch0, ch1, threshold, rd_idx,
    input done, hit, wr_idx, rd_ch0, rd_ch1
  );

  // Transfer unit side
  modport unit (
    input conv_end, ch0, ch1, threshold, rd_idx,
    output done, hit, wr_idx, rd_ch0, rd_ch1
  );
endinterface

// file: sls_interval_timer.sv
// Cascaded minute tick timer and interval count timer
`timescale 1ns/100ps
module sls_interval_timer #(
  parameter logic [33:0] MINUTE_CYCLES = sls_pkg::MINUTE_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Events
  output logic minute_tick_o,
  output logic snooze_req_o
);

  typedef struct packed {
    logic [33:0] min_cnt;
    logic [4:0] int_cnt;
    logic tick;
    logic req;
  } sls_tmr_t;

  sls_tmr_t r_reg;
  sls_tmr_t r_next;

  // Minute underflow feeds the interval counter as its count source
  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    r_next.req = 1'b0;
    if (r_reg.min_cnt == MINUTE_CYCLES - 34'h1) begin
      r_next.min_cnt = 34'h0;
      r_next.tick = 1'b1;
      if (r_reg.int_cnt == sls_pkg::INTERVAL_COUNT - 5'h1) begin
        r_next.int_cnt = 5'h0;
        r_next.req = 1'b1;
      end else begin
        r_next.int_cnt = r_reg.int_cnt + 5'h1;
      end
    end else begin
      r_next.min_cnt = r_reg.min_cnt + 34'h1;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign minute_tick_o = r_reg.tick;
  assign snooze_req_o = r_reg.req;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_req_on_tick: assert property (
    snooze_req_o |-> minute_tick_o && r_reg.int_cnt == 5'h0)
    else $error("interval request without thirtieth minute");

  a_tick_restart: assert property (
    minute_tick_o |-> r_reg.min_cnt == 34'h0)
    else $error("minute tick without counter restart");

endmodule

// file: sls_xfer_unit.sv
// Chained transfer unit with repeat buffers and threshold comparator
`timescale 1ns/100ps
module sls_xfer_unit (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Sequencer link
  sls_xfer_if.unit xf
);

  typedef struct packed {
    sls_pkg::sls_xstep_t step;
    logic [3:0] idx;
    logic [11:0] lat0;
    logic [11:0] lat1;
    logic [11:0] ref_val;
    logic [11:0] inp_val;
    logic done;
    logic hit;
    logic [11:0] rd0;
    logic [11:0] rd1;
  } sls_xu_t;

  sls_xu_t r_reg;
  sls_xu_t r_next;
  logic [11:0] buf0 [16];
  logic [11:0] buf1 [16];

  // Repeat mode destination: advance and wrap at the buffer end
  function automatic logic [3:0] idx_inc(input logic [3:0] i);
    idx_inc = (i == sls_pkg::BUF_LAST) ? 4'h0 : i + 4'h1;
  endfunction

  // One conversion end drives the whole four-move chain
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.hit = 1'b0;
    r_next.rd0 = buf0[xf.rd_idx];
    r_next.rd1 = buf1[xf.rd_idx];
    case (r_reg.step)
      sls_pkg::XS_IDLE: begin
        if (xf.conv_end) begin
          r_next.lat0 = xf.ch0;
          r_next.lat1 = xf.ch1;
          r_next.step = sls_pkg::XS_CH0;
        end
      end
      sls_pkg::XS_CH0: r_next.step = sls_pkg::XS_CH1;
      sls_pkg::XS_CH1: begin
        r_next.idx = idx_inc(r_reg.idx);
        r_next.step = sls_pkg::XS_REF;
      end
      sls_pkg::XS_REF: begin
        r_next.ref_val = xf.threshold;
        r_next.step = sls_pkg::XS_INP;
      end
      sls_pkg::XS_INP: begin
        r_next.inp_val = r_reg.lat1;
        r_next.step = sls_pkg::XS_CMP;
      end
      sls_pkg::XS_CMP: begin
        r_next.hit = (r_reg.inp_val >= r_reg.ref_val);
        r_next.done = 1'b1;
        r_next.step = sls_pkg::XS_IDLE;
      end
      default: r_next.step = sls_pkg::XS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Buffer memory kept apart from the state word; contents need no reset
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && r_reg.step == sls_pkg::XS_CH0) begin
      buf0[r_reg.idx] <= r_reg.lat0;
    end
    if (ce_i && r_reg.step == sls_pkg::XS_CH1) begin
      buf1[r_reg.idx] <= r_reg.lat1;
    end
  end

  assign xf.done = r_reg.done;
  assign xf.hit = r_reg.hit;
  assign xf.wr_idx = r_reg.idx;
  assign xf.rd_ch0 = r_reg.rd0;
  assign xf.rd_ch1 = r_reg.rd1;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  sequence s_chain;
    r_reg.step == sls_pkg::XS_CH0 ##1 r_reg.step == sls_pkg::XS_CH1 ##1 r_reg.step == sls_pkg::XS_REF
      ##1 r_reg.step == sls_pkg::XS_INP ##1 r_reg.step == sls_pkg::XS_CMP;
  endsequence

  a_chain_order: assert property (
    r_reg.step == sls_pkg::XS_IDLE && xf.conv_end |=> s_chain ##1 xf.done)
    else $error("transfer chain out of order");

  a_compare_ge: assert property (
    xf.done |-> xf.hit == ($past(r_reg.inp_val) >= $past(r_reg.ref_val)))
    else $error("compare result wrong");

  a_buf_wrap: assert property (
    r_reg.step == sls_pkg::XS_CH1 |=> r_reg.idx == idx_inc($past(r_reg.idx)))
    else $error("buffer index did not advance");

  a_ch0_store: assert property (
    r_reg.step == sls_pkg::XS_CH0 |=> buf0[$past(r_reg.idx)] == $past(r_reg.lat0))
    else $error("channel 0 sample not stored");

endmodule

// file: sls_sequencer.sv
// Top of the snooze logging sequencer: power mode control and wake handling
`timescale 1ns/100ps

// Functional notes
// - First timer underflows once per minute and clocks the second timer.
// - Second timer requests snooze after thirty minute underflows.
// - Snooze request starts a conversion through the event link.
// - Each snooze that reaches conversion end stores both channel results into buffers by hardware.
// - Chain moves ch0, ch1, threshold to reference, ch1 to compare input.
// - Buffers wrap in repeat mode; one conversion end triggers all moves.
// - Comparator fires when result is greater than or equal threshold.
// - Comparator event cancels snooze and enters normal mode.
// - Chain completion ends snooze back to standby.
// - Alarm, button or comparator wake into normal mode for serial output.
// - Alarm cancels low power once every twenty-four hours.
// - After serial output the device returns to standby cycling.
// - After an alarm wake the next alarm is set before standby.
module sls_sequencer #(
  parameter logic [33:0] MINUTE_CYCLES = sls_pkg::MINUTE_CYCLES,
  parameter logic [10:0] ALARM_MINUTES = sls_pkg::ALARM_MINUTES
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Converter
  output logic adc_start_o,
  input wire logic adc_end_i,
  input wire logic [11:0] adc_ch0_i,
  input wire logic [11:0] adc_ch1_i,
  // Level judgment setting
  input wire logic [11:0] threshold_i,
  // Wake pin and serial port
  input wire logic button_irq_i,
  output logic tx_req_o,
  input wire logic serial_done_i,
  // Buffer readout
  input wire logic [3:0] rd_idx_i,
  output logic [11:0] rd_ch0_o,
  output logic [11:0] rd_ch1_o,
  output logic [3:0] wr_idx_o,
  // Status
  output logic [1:0] mode_o,
  output logic [1:0] wake_cause_o,
  output logic cmp_irq_o,
  output logic xfer_done_o,
  output logic alarm_pend_o
);

  // ----------------------------------------------------------------
  // State word
  // ----------------------------------------------------------------
  typedef struct packed {
    sls_pkg::sls_state_t st;
    logic [1:0] mode;
    logic [1:0] cause;
    logic adc_start;
    logic tx_req;
    logic alarm_pend;
    logic [10:0] alarm_min;
    logic btn_s1;
    logic btn_s2;
    logic btn_s3;
    logic cmp_irq;
    logic xfer_done;
    logic [3:0] wr_idx;
    logic [11:0] rd0;
    logic [11:0] rd1;
  } sls_seq_t;

  sls_seq_t r_reg;
  sls_seq_t r_next;
  logic minute_tick;
  logic snooze_req;
  logic btn_edge;
  logic alarm_set;

  sls_xfer_if xf ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  // Cascaded timers: minute source and thirty-minute interval
  sls_interval_timer #(
    .MINUTE_CYCLES(MINUTE_CYCLES)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .minute_tick_o(minute_tick),
    .snooze_req_o(snooze_req)
  );

  // Chained transfer and threshold compare
  sls_xfer_unit u_xfer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .xf(xf)
  );

  // Mode presented to the outside for a given sequencer state
  function automatic logic [1:0] mode_of(input sls_pkg::sls_state_t s);
    case (s)
      sls_pkg::ST_CONV: mode_of = sls_pkg::MODE_SNOOZE;
      sls_pkg::ST_XFER: mode_of = sls_pkg::MODE_SNOOZE;
      sls_pkg::ST_NORMAL: mode_of = sls_pkg::MODE_NORMAL;
      sls_pkg::ST_REARM: mode_of = sls_pkg::MODE_NORMAL;
      default: mode_of = sls_pkg::MODE_STANDBY;
    endcase
  endfunction

  // Wake cause of alarm and button wakes, transfer step included; the sticky alarm outranks the button
  function automatic logic [1:0] pin_cause(input logic pend);
    pin_cause = pend ? sls_pkg::CAUSE_ALARM : sls_pkg::CAUSE_BUTTON;
  endfunction

  // ----------------------------------------------------------------
  // Link to the transfer unit
  // ----------------------------------------------------------------
  // Conversion end only counts while a snooze conversion is pending
  assign xf.conv_end = adc_end_i && r_reg.st == sls_pkg::ST_CONV;
  assign xf.ch0 = adc_ch0_i;
  assign xf.ch1 = adc_ch1_i;
  assign xf.threshold = threshold_i;
  assign xf.rd_idx = rd_idx_i;

  // Button edge only from the settled stages, never the first one
  assign btn_edge = r_reg.btn_s2 && !r_reg.btn_s3;

  // Daily alarm reaches its mark on the last minute of the day
  assign alarm_set = minute_tick && (r_reg.alarm_min == ALARM_MINUTES - 11'h1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.adc_start = 1'b0;
    r_next.tx_req = 1'b0;
    r_next.btn_s1 = button_irq_i;
    r_next.btn_s2 = r_reg.btn_s1;
    r_next.btn_s3 = r_reg.btn_s2;
    r_next.cmp_irq = xf.hit;
    r_next.xfer_done = xf.done;
    r_next.wr_idx = xf.wr_idx;
    r_next.rd0 = xf.rd_ch0;
    r_next.rd1 = xf.rd_ch1;

    // Real-time alarm: minutes of the day, sticky pending flag
    if (minute_tick) begin
      r_next.alarm_min = alarm_set ? 11'h0 : r_reg.alarm_min + 11'h1;
    end
    if (alarm_set) begin
      r_next.alarm_pend = 1'b1;
    end

    case (r_reg.st)
      sls_pkg::ST_STANDBY: begin
        if (r_reg.alarm_pend || btn_edge) begin
          r_next.st = sls_pkg::ST_NORMAL;
          r_next.cause = pin_cause(r_reg.alarm_pend);
          r_next.tx_req = 1'b1;
        end else if (snooze_req) begin
          r_next.st = sls_pkg::ST_CONV;
          r_next.adc_start = 1'b1;
        end
      end
      sls_pkg::ST_CONV: begin
        if (r_reg.alarm_pend || btn_edge) begin
          r_next.st = sls_pkg::ST_NORMAL;
          r_next.cause = pin_cause(r_reg.alarm_pend);
          r_next.tx_req = 1'b1;
        end else if (adc_end_i) begin
          r_next.st = sls_pkg::ST_XFER;
        end
      end
      sls_pkg::ST_XFER: begin
        // Comparator checked first so a same-cycle completion cannot hide it
        if (xf.hit) begin
          r_next.st = sls_pkg::ST_NORMAL;
          r_next.cause = sls_pkg::CAUSE_CMP;
          r_next.tx_req = 1'b1;
        end else if (r_reg.alarm_pend || btn_edge) begin
          r_next.st = sls_pkg::ST_NORMAL;
          r_next.cause = pin_cause(r_reg.alarm_pend);
          r_next.tx_req = 1'b1;
        end else if (xf.done) begin
          r_next.st = sls_pkg::ST_STANDBY;
        end
      end
      sls_pkg::ST_NORMAL: begin
        // Wake events arriving here are not queued, except the sticky alarm
        if (serial_done_i) begin
          r_next.st = (r_reg.cause == sls_pkg::CAUSE_ALARM) ? sls_pkg::ST_REARM : sls_pkg::ST_STANDBY;
        end
      end
      sls_pkg::ST_REARM: begin
        // Next alarm one day on; a fresh alarm in this cycle still wins
        r_next.alarm_min = 11'h0;
        r_next.alarm_pend = alarm_set;
        r_next.st = sls_pkg::ST_STANDBY;
      end
      default: r_next.st = sls_pkg::ST_STANDBY;
    endcase
    r_next.mode = mode_of(r_next.st);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset, whole word frozen while the enable is low
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state word
  assign adc_start_o = r_reg.adc_start;
  assign tx_req_o = r_reg.tx_req;
  assign mode_o = r_reg.mode;
  assign wake_cause_o = r_reg.cause;
  assign cmp_irq_o = r_reg.cmp_irq;
  assign xfer_done_o = r_reg.xfer_done;
  assign wr_idx_o = r_reg.wr_idx;
  assign rd_ch0_o = r_reg.rd0;
  assign rd_ch1_o = r_reg.rd1;
  assign alarm_pend_o = r_reg.alarm_pend;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  sequence s_snooze_start;
    r_reg.st == sls_pkg::ST_CONV && adc_start_o && mode_o == sls_pkg::MODE_SNOOZE;
  endsequence

  sequence s_wake_tx(logic [1:0] c);
    r_reg.st == sls_pkg::ST_NORMAL && tx_req_o && wake_cause_o == c ##1 !tx_req_o;
  endsequence

  sequence s_rearm_done;
    r_reg.st == sls_pkg::ST_REARM ##1 r_reg.st == sls_pkg::ST_STANDBY && r_reg.alarm_min == 11'h0;
  endsequence

  a_snooze_entry: assert property (
    r_reg.st == sls_pkg::ST_STANDBY && snooze_req && !r_reg.alarm_pend && !btn_edge |=> s_snooze_start)
    else $error("interval request did not enter snooze");

  a_adc_start_once: assert property (
    adc_start_o |=> !adc_start_o && r_reg.st != sls_pkg::ST_STANDBY)
    else $error("conversion start not a single pulse");

  a_cmp_wake: assert property (
    r_reg.st == sls_pkg::ST_XFER && xf.hit |=> s_wake_tx(sls_pkg::CAUSE_CMP))
    else $error("comparator event did not wake");

  a_cmp_priority: assert property (
    r_reg.st == sls_pkg::ST_XFER && xf.hit && xf.done |=> mode_o == sls_pkg::MODE_NORMAL)
    else $error("completion won over comparator wake");

  a_done_standby: assert property (
    r_reg.st == sls_pkg::ST_XFER && xf.done && !xf.hit && !r_reg.alarm_pend && !btn_edge
      |=> mode_o == sls_pkg::MODE_STANDBY)
    else $error("completion did not return to standby");

  a_alarm_wake: assert property (
    r_reg.st == sls_pkg::ST_STANDBY && r_reg.alarm_pend |=> s_wake_tx(sls_pkg::CAUSE_ALARM))
    else $error("alarm did not wake from standby");

  a_alarm_daily: assert property (
    minute_tick && r_reg.alarm_min == ALARM_MINUTES - 11'h1 |=> r_reg.alarm_pend && r_reg.alarm_min == 11'h0)
    else $error("daily alarm not raised");

  a_tx_return: assert property (
    r_reg.st == sls_pkg::ST_NORMAL && serial_done_i && wake_cause_o != sls_pkg::CAUSE_ALARM
      |=> mode_o == sls_pkg::MODE_STANDBY)
    else $error("no return to standby after output");

  a_alarm_rearm: assert property (
    r_reg.st == sls_pkg::ST_NORMAL && serial_done_i && wake_cause_o == sls_pkg::CAUSE_ALARM
      && !minute_tick |=> s_rearm_done)
    else $error("next alarm not set before standby");

  a_btn_wake: assert property (
    r_reg.st == sls_pkg::ST_STANDBY && btn_edge && !r_reg.alarm_pend |=> s_wake_tx(sls_pkg::CAUSE_BUTTON))
    else $error("button did not wake from standby");

  a_conv_to_xfer: assert property (
    r_reg.st == sls_pkg::ST_CONV && adc_end_i && !r_reg.alarm_pend && !btn_edge
      |=> r_reg.st == sls_pkg::ST_XFER && mode_o == sls_pkg::MODE_SNOOZE)
    else $error("conversion end did not start transfers");

  a_normal_hold: assert property (
    r_reg.st == sls_pkg::ST_NORMAL && !serial_done_i |=> mode_o == sls_pkg::MODE_NORMAL)
    else $error("normal mode left before output end");

  a_cause_hold: assert property (
    r_reg.st == sls_pkg::ST_NORMAL |=> $stable(wake_cause_o))
    else $error("wake cause changed in normal mode");

endmodule

// file: sls_far_model.sv
// Far side model: converter and serial port answering the sequencer
`timescale 1ns/100ps
module sls_far_model (
  // Clock
  input wire logic sys_clk_i,
  // Converter
  input wire logic adc_start_i,
  output logic adc_end_o,
  output logic [11:0] adc_ch0_o,
  output logic [11:0] adc_ch1_o,
  // Serial port
  input wire logic tx_req_i,
  output logic serial_done_o,
  // Bench settings
  input wire logic [11:0] ch0_i,
  input wire logic [11:0] ch1_i,
  input wire logic [7:0] dly_i
);
  int conv_cnt = -1;
  int tx_cnt = -1;
  logic [11:0] last0 = 12'h000;
  logic [11:0] last1 = 12'h000;

  // Idle outputs at time zero
  initial begin
    adc_end_o = 1'b0;
    serial_done_o = 1'b0;
    adc_ch0_o = 12'hfff;
    adc_ch1_o = 12'hfff;
  end

  // Conversion ends dly_i + 1 cycles after the start is sampled; data valid only with the end pulse
  always @(posedge sys_clk_i) begin
    adc_end_o <= 1'b0;
    adc_ch0_o <= ~last0; // Stale data never looks like a fresh sample
    adc_ch1_o <= ~last1;
    if (adc_start_i) begin
      conv_cnt <= dly_i;
    end else if (conv_cnt > 0) begin
      conv_cnt <= conv_cnt - 1;
    end else if (conv_cnt == 0) begin
      conv_cnt <= -1;
      adc_end_o <= 1'b1;
      adc_ch0_o <= ch0_i;
      adc_ch1_o <= ch1_i;
      last0 <= ch0_i;
      last1 <= ch1_i;
    end
  end

  // Serial output finishes dly_i + 1 cycles after the request is sampled
  always @(posedge sys_clk_i) begin
    serial_done_o <= 1'b0;
    if (tx_req_i) begin
      tx_cnt <= dly_i;
    end else if (tx_cnt > 0) begin
      tx_cnt <= tx_cnt - 1;
    end else if (tx_cnt == 0) begin
      tx_cnt <= -1;
      serial_done_o <= 1'b1;
    end
  end
endmodule

// file: sls_sequencer_tb_top.sv
// Self-checking testbench of the snooze logging sequencer
`timescale 1ns/100ps
module sls_sequencer_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [33:0] MIN_CYC = 34'h4; // Short minute keeps the run small
  localparam logic [10:0] ALM_MIN = 11'h7ff;
  localparam logic [11:0] THR = 12'h800;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic adc_start_o, adc_end_i, tx_req_o, serial_done_i, button_irq_i = 1'b0;
  logic cmp_irq_o, xfer_done_o, alarm_pend_o;
  logic [11:0] adc_ch0_i, adc_ch1_i, rd_ch0_o, rd_ch1_o;
  logic [11:0] ch0 = 12'h000;
  logic [11:0] ch1 = 12'h000;
  logic [11:0] threshold_i = THR;
  logic [3:0] rd_idx_i = 4'h0;
  logic [3:0] wr_idx_o;
  logic [1:0] mode_o, wake_cause_o;
  logic [7:0] dly = 8'h01;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_start = -1;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;

  sls_sequencer #(.MINUTE_CYCLES(MIN_CYC), .ALARM_MINUTES(ALM_MIN)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .adc_start_o(adc_start_o),
    .adc_end_i(adc_end_i), .adc_ch0_i(adc_ch0_i), .adc_ch1_i(adc_ch1_i), .threshold_i(threshold_i),
    .button_irq_i(button_irq_i), .tx_req_o(tx_req_o), .serial_done_i(serial_done_i),
    .rd_idx_i(rd_idx_i), .rd_ch0_o(rd_ch0_o), .rd_ch1_o(rd_ch1_o), .wr_idx_o(wr_idx_o),
    .mode_o(mode_o), .wake_cause_o(wake_cause_o), .cmp_irq_o(cmp_irq_o),
    .xfer_done_o(xfer_done_o), .alarm_pend_o(alarm_pend_o));

  sls_far_model far (
    .sys_clk_i(sys_clk_i), .adc_start_i(adc_start_o), .adc_end_o(adc_end_i),
    .adc_ch0_o(adc_ch0_i), .adc_ch1_o(adc_ch1_i), .tx_req_i(tx_req_o),
    .serial_done_o(serial_done_i), .ch0_i(ch0), .ch1_i(ch1), .dly_i(dly));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait; 0 start, 1 done, 2 serial request, 3 alarm, 4 standby
  task automatic wait_on(input int sel, input int lim);
    logic hit;
    hit = 1'b0;
    #1;
    for (int i = 0; i < lim && !hit; i++) begin
      case (sel)
        0: hit = adc_start_o === 1'b1;
        1: hit = xfer_done_o === 1'b1;
        2: hit = tx_req_o === 1'b1;
        3: hit = alarm_pend_o === 1'b1;
        default: hit = mode_o === sls_pkg::MODE_STANDBY;
      endcase
      if (!hit) begin
        @(posedge sys_clk_i);
        #1;
      end
    end
    if (!hit) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, sel, 1);
      final_report();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // One snooze period: convert, store, judge, then standby or normal
  task automatic t_log(input logic [11:0] v0, input logic [11:0] v1, input logic [7:0] d, input logic chk_per);
    logic [3:0] idx;
    logic h;
    @(posedge sys_clk_i);
    ch0 <= v0;
    ch1 <= v1;
    dly <= d;
    h = v1 >= threshold_i; // Threshold as set by the bench before this period
    wait_on(0, 300);
    check(mode_o, sls_pkg::MODE_SNOOZE);
    if (chk_per) check(16'(cyc - last_start), 16'(sls_pkg::INTERVAL_COUNT * MIN_CYC));
    last_start = cyc;
    idx = wr_idx_o;
    wait_on(1, 300);
    check(cmp_irq_o, h);
    check(mode_o, h ? sls_pkg::MODE_NORMAL : sls_pkg::MODE_STANDBY);
    check(tx_req_o, h);
    check(wr_idx_o, 4'(idx + 4'h1));
    if (h) begin
      check(wake_cause_o, sls_pkg::CAUSE_CMP);
      wait_on(4, 100);
    end
    @(posedge sys_clk_i);
    rd_idx_i <= idx;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check(rd_ch0_o, v0);
    check(rd_ch1_o, v1);
  endtask

  // Button edge in standby wakes into normal, serial end returns to standby
  task automatic t_button();
    wait_on(4, 100);
    @(posedge sys_clk_i);
    button_irq_i <= 1'b1;
    wait_on(2, 10);
    check(mode_o, sls_pkg::MODE_NORMAL);
    check(wake_cause_o, sls_pkg::CAUSE_BUTTON);
    @(posedge sys_clk_i);
    button_irq_i <= 1'b0;
    wait_on(4, 100);
    check(alarm_pend_o, 1'b0);
  endtask

  // Daily alarm wakes, rearms, then returns to standby
  task automatic t_alarm();
    wait_on(3, 9000);
    wait_on(2, 10);
    check(mode_o, sls_pkg::MODE_NORMAL);
    check(wake_cause_o, sls_pkg::CAUSE_ALARM);
    wait_on(4, 100);
    check(alarm_pend_o, 1'b0);
    check(mode_o, sls_pkg::MODE_STANDBY);
  endtask

  // Enable low freezes timers and modes; a snooze start falls due inside the window
  task automatic t_freeze();
    logic seen;
    seen = 1'b0;
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    repeat (200) begin
      @(posedge sys_clk_i);
      #1;
      seen = seen | adc_start_o;
    end
    check(seen, 1'b0);
    check(mode_o, sls_pkg::MODE_STANDBY);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    check({mode_o, wake_cause_o, tx_req_o, adc_start_o, alarm_pend_o}, 16'h0000);
    check(wr_idx_o, 4'h0);
    // Seventeen quiet periods wrap the buffer; delay alternates prompt and slow
    for (int i = 0; i < 17; i++) begin
      t_log(12'(i * 37), 12'h7ff - 12'(i), (i % 2) ? 8'h14 : 8'h01, i > 0);
    end
    t_log(12'h123, THR, 8'h01, 1'b1);
    t_log(12'h0ab, 12'hfff, 8'h14, 1'b0);
    t_log(12'h456, 12'h7ff, 8'h01, 1'b0);
    t_button();
    t_alarm();
    t_freeze();
    threshold_i <= 12'h0ff;
    t_log(12'h321, 12'h100, 8'h01, 1'b0);
    final_report();
  end
endmodule
